// ### inc/twc_pkg.sv
// Purpose: Shared constants and helpers for the two-wire bus controller
// Assumes: Registers sit on a simple 3-bit select, 8-bit data CPU port
// Notes: Status codes are local values, not a published table
package twc_pkg;
  // Register selects on the CPU port
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_ADDR = 3'h3;
  localparam logic [2:0] REG_RATE = 3'h4;
  // bus_control, address and status bit positions
  localparam int CB_INT = 7;
  localparam int CB_EA = 6;
  localparam int CB_STA = 5;
  localparam int CB_STO = 4;
  localparam int CB_EN = 2;
  localparam int CB_IE = 0;
  localparam int AB_GCE = 0;
  localparam int SB_RSVD = 2;
  // Reset values
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [6:0] GC_ADDR = 7'h00;
  // Status codes
  localparam logic [4:0] SC_NOINFO = 5'h1F;
  localparam logic [4:0] SC_START = 5'h01;
  localparam logic [4:0] SC_RSTART = 5'h02;
  localparam logic [4:0] SC_ADDR_ACK = 5'h03;
  localparam logic [4:0] SC_ADDR_NACK = 5'h04;
  localparam logic [4:0] SC_DATA_ACK = 5'h05;
  localparam logic [4:0] SC_DATA_NACK = 5'h06;
  localparam logic [4:0] SC_ARB_LOST = 5'h07;
  localparam logic [4:0] SC_RX_ACK = 5'h08;
  localparam logic [4:0] SC_RX_NACK = 5'h09;
  localparam logic [4:0] SC_SLV_ADDR = 5'h0A;
  localparam logic [4:0] SC_SLV_GC = 5'h0B;
  localparam logic [4:0] SC_SLV_RX = 5'h0C;
  localparam logic [4:0] SC_SLV_TX_ACK = 5'h0D;
  localparam logic [4:0] SC_SLV_TX_NACK = 5'h0E;
  localparam logic [4:0] SC_SLV_STOP = 5'h0F;
  // Timing and bit counting
  localparam logic [15:0] HALF_BASE = 16'h0008;
  localparam logic [3:0] PRE_ACK = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] PH_0 = 2'h0;
  localparam logic [1:0] PH_1 = 2'h1;
  localparam logic [1:0] PH_2 = 2'h2;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  typedef enum logic [2:0] {S_IDLE, S_WAIT_FREE, S_START, S_BYTE, S_STOP} twc_state_e;
  // Half an SCL period in clk_sys cycles: base plus divider times 4^ps
  function automatic logic [15:0] half_period(input logic [7:0] div, input logic [1:0] ps);
    return HALF_BASE + 16'({8'h00, div} << {ps, 1'b0});
  endfunction
  function automatic logic addr_hit(input logic [6:0] rx, input logic [6:0] own, input logic gce);
    return (rx == own) || (gce && (rx == GC_ADDR));
  endfunction
endpackage

// ### hdl/twc_ctrl.sv
// Purpose: Byte-oriented two-wire bus controller, master and slave
// Assumes: SCL and SDA are open drain; CPU port on clk_sys
// Notes: Received bytes also stream out through an 8-word FIFO
`timescale 1ns/1ps
module twc_fifo
  import twc_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
)
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset
  input wire logic in_valid, // Push request
  output logic in_ready, // Room left
  input wire logic [W-1:0] in_data, // Push data
  output logic out_valid, // Data present
  input wire logic out_ready, // Pop request
  output logic [W-1:0] out_data // Head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];
  always_ff @(posedge clk_sys)
  begin
    if (in_valid && in_ready)
      mem[wr_q[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_q <= wr_q + 1'b1;
      if (out_valid && out_ready)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule // twc_fifo

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Start request waits for a free bus, then sends START.
// - Master stop request sends STOP, then clears itself.
// - Slave stop request sends nothing; unaddress and release both lines.
// - Data write with job flag low sets collision; high clears it.
// - Enable hands the pins to the controller and turns on pin conditioning.
// - Disable aborts everything at once.
// - Interrupt follows job flag, gated by local and global enables.
// - Status register upper five bits hold the status code.
// - Status bit 2 reads zero.
// - Low status bits select prescale 1, 4, 16, 64.
// - Data writes accepted only with job flag set; then held stable.
// - Bus data shifts in while shifting out; register holds last byte.
// - Data contents after sleep wake-up are undefined.
// - Arbitration loss drops to slave without losing the byte; automatic ack.
// - Upper seven address bits are the own slave address.
// - General call enable also matches address zero; match raises job flag.
// - No bus operation while job flag set; start right after clearing.
// - Job flag and status after START, address or data byte.
// - No job flag after a STOP sent as master; an addressed slave flags SC_SLV_STOP.
// - Job flag cleared by writing one or by disable; master or addressed slave holds SCL low while set.
// - With ack enable, ack own address, general call or received data.
module twc_ctrl
  import twc_pkg::*;
(
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic rst, // Async reset, active high
  input wire logic [2:0] reg_sel, // Register select
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, one cycle later
  input wire logic global_irq_en, // CPU global interrupt enable
  output logic irq, // Interrupt request
  output logic pin_ctrl_en, // Pin slew and spike filter enable
  input wire logic scl_in, // SCL pin level
  output logic scl_out, // SCL drive value
  output logic scl_oe_n, // SCL pull low when 0
  input wire logic sda_in, // SDA pin level
  output logic sda_out, // SDA drive value
  output logic sda_oe_n, // SDA pull low when 0
  output logic [7:0] rx_data, // Received byte
  output logic rx_valid, // Received byte present
  input wire logic rx_ready // Consumer takes byte
);
  twc_state_e state_q;
  logic [1:0] scl_sync_q, sda_sync_q;
  logic scl_prev_q, sda_prev_q, scl_s, sda_s;
  logic scl_rise, scl_fall, bus_start, bus_stop, bus_busy_q;
  logic wr_ctrl, wr_stat, wr_data, wr_addr, wr_rate;
  logic int_flag_q, ea_q, sta_q, sto_q, wc_q, en_q, ie_q, gce_q;
  logic [1:0] ps_q, phase_q;
  logic [7:0] shift_q, rate_q, rdata_q;
  logic [6:0] own_q;
  logic [4:0] status_q;
  logic master_q, addressed_q, tx_q, addr_ph_q, sda_rel_q, scl_low_q;
  logic ack_q, arb_q, pend_q, rs_q, push_q, go, hit, fifo_rdy;
  logic [3:0] bit_cnt_q;
  logic [15:0] timer_q, half;
  logic half_done;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end
  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign bus_stop = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      bus_busy_q <= 1'b0;
    else if (!en_q || bus_stop)
      bus_busy_q <= 1'b0;
    else if (bus_start)
      bus_busy_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port
  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_data = 1'b0;
    wr_addr = 1'b0;
    wr_rate = 1'b0;
    if (reg_sel == REG_CTRL)
      wr_ctrl = reg_wr;
    else if (reg_sel == REG_STAT)
      wr_stat = reg_wr;
    else if (reg_sel == REG_DATA)
      wr_data = reg_wr;
    else if (reg_sel == REG_ADDR)
      wr_addr = reg_wr;
    else if (reg_sel == REG_RATE)
      wr_rate = reg_wr;
  end

  // Reserved control bit is dropped on write
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ea_q <= 1'b0;
      sta_q <= 1'b0;
      en_q <= 1'b0;
      ie_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      ea_q <= reg_wdata[CB_EA];
      sta_q <= reg_wdata[CB_STA];
      en_q <= reg_wdata[CB_EN];
      ie_q <= reg_wdata[CB_IE];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ps_q <= 2'h0;
      own_q <= GC_ADDR;
      gce_q <= 1'b0;
      rate_q <= ZERO8;
    end
    else
    begin
      if (wr_stat)
        ps_q <= reg_wdata[1:0];
      if (wr_addr)
      begin
        own_q <= reg_wdata[7:1];
        gce_q <= reg_wdata[AB_GCE];
      end
      if (wr_rate)
        rate_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wc_q <= 1'b0;
    else if (wr_data)
      wc_q <= !int_flag_q;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_q <= ZERO8;
    else if (reg_sel == REG_CTRL)
      rdata_q <= {int_flag_q, ea_q, sta_q, sto_q, wc_q, en_q, 1'b0, ie_q};
    else if (reg_sel == REG_STAT)
      rdata_q <= {int_flag_q ? status_q : SC_NOINFO, 1'b0, ps_q};
    else if (reg_sel == REG_DATA)
      rdata_q <= shift_q;
    else if (reg_sel == REG_ADDR)
      rdata_q <= {own_q, gce_q};
    else if (reg_sel == REG_RATE)
      rdata_q <= rate_q;
    else
      rdata_q <= ZERO8;
  end
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Bus engine
  assign half = half_period(rate_q, ps_q);
  assign half_done = (timer_q >= half);
  assign hit = addr_hit(shift_q[7:1], own_q, gce_q);
  // Launch only with the flag low, so nothing moves while software works
  assign go = (state_q == S_IDLE) && pend_q && !int_flag_q && en_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      int_flag_q <= 1'b0;
      status_q <= SC_NOINFO;
      sto_q <= 1'b0;
      shift_q <= DATA_RST;
      master_q <= 1'b0;
      addressed_q <= 1'b0;
      tx_q <= 1'b0;
      addr_ph_q <= 1'b0;
      sda_rel_q <= 1'b1;
      scl_low_q <= 1'b0;
      phase_q <= PH_0;
      bit_cnt_q <= 4'h0;
      timer_q <= 16'h0000;
      ack_q <= 1'b1;
      arb_q <= 1'b0;
      pend_q <= 1'b0;
      rs_q <= 1'b0;
      push_q <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      timer_q <= timer_q + 16'h0001;
      if (wr_ctrl)
        sto_q <= reg_wdata[CB_STO];
      if (wr_ctrl && reg_wdata[CB_INT])
      begin
        int_flag_q <= 1'b0;
        pend_q <= 1'b1;
      end
      if (wr_data && int_flag_q)
        shift_q <= reg_wdata;
      if (!en_q)
      begin
        state_q <= S_IDLE;
        int_flag_q <= 1'b0;
        sto_q <= 1'b0;
        pend_q <= 1'b0;
        master_q <= 1'b0;
        addressed_q <= 1'b0;
        sda_rel_q <= 1'b1;
        scl_low_q <= 1'b0;
      end
      else
      case (state_q)
        S_IDLE:
        begin
          if (go)
          begin
            pend_q <= 1'b0;
            timer_q <= 16'h0000;
            phase_q <= PH_0;
            bit_cnt_q <= 4'h0;
            if (sta_q)
            begin
              rs_q <= master_q;
              state_q <= (master_q || !bus_busy_q) ? S_START : S_WAIT_FREE;
            end
            else if (sto_q && master_q)
              state_q <= S_STOP;
            else if (sto_q)
            begin
              addressed_q <= 1'b0;
              sto_q <= 1'b0;
              sda_rel_q <= 1'b1;
            end
            else if ((master_q || addressed_q) && (tx_q || fifo_rdy))
            begin
              state_q <= S_BYTE;
              sda_rel_q <= tx_q ? shift_q[7] : 1'b1;
            end
            else
              pend_q <= 1'b1;
          end
          else if (bus_start && !master_q && !int_flag_q && ea_q)
          begin
            state_q <= S_BYTE;
            addr_ph_q <= 1'b1;
            tx_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            sda_rel_q <= 1'b1;
            addressed_q <= 1'b0;
          end
        end
        S_WAIT_FREE:
        begin
          timer_q <= 16'h0000;
          if (!bus_busy_q)
            state_q <= S_START;
        end
        S_START:
        begin
          case (phase_q)
            PH_0:
            begin
              sda_rel_q <= 1'b1;
              scl_low_q <= 1'b0;
              if (!scl_s || !sda_s)
                timer_q <= 16'h0000;
              else if (!master_q && bus_busy_q)
                state_q <= S_WAIT_FREE;
              else if (half_done)
              begin
                sda_rel_q <= 1'b0;
                timer_q <= 16'h0000;
                phase_q <= PH_1;
              end
            end
            PH_1:
            begin
              if (half_done)
              begin
                scl_low_q <= 1'b1;
                master_q <= 1'b1;
                timer_q <= 16'h0000;
                phase_q <= PH_2;
              end
            end
            default:
            begin
              if (half_done)
              begin
                state_q <= S_IDLE;
                int_flag_q <= 1'b1;
                status_q <= rs_q ? SC_RSTART : SC_START;
                tx_q <= 1'b1;
                addr_ph_q <= 1'b1;
              end
            end
          endcase
        end
        S_BYTE:
        begin
          // Master clock; a slave holding SCL low freezes the high count
          if (master_q && scl_low_q && half_done)
          begin
            scl_low_q <= 1'b0;
            timer_q <= 16'h0000;
          end
          else if (master_q && !scl_low_q && (!scl_s || half_done))
          begin
            scl_low_q <= scl_s;
            timer_q <= 16'h0000;
          end
          if (scl_rise && bit_cnt_q != ACK_BIT)
          begin
            shift_q <= {shift_q[6:0], sda_s};
            if (master_q && tx_q && sda_rel_q && !sda_s)
            begin
              master_q <= 1'b0;
              arb_q <= 1'b1;
              tx_q <= 1'b0;
              scl_low_q <= 1'b0;
            end
          end
          else if (scl_rise)
            ack_q <= sda_s;
          if (!master_q && bus_stop)
          begin
            state_q <= S_IDLE;
            sda_rel_q <= 1'b1;
            addressed_q <= 1'b0;
            if (addressed_q)
            begin
              int_flag_q <= 1'b1;
              status_q <= SC_SLV_STOP;
            end
          end
          else if (scl_fall && bit_cnt_q != ACK_BIT)
          begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == PRE_ACK)
              sda_rel_q <= tx_q || !(ea_q && (!addr_ph_q || master_q || hit));
            else
              sda_rel_q <= tx_q ? shift_q[7] : 1'b1;
          end
          else if (scl_fall)
          begin
            state_q <= S_IDLE;
            bit_cnt_q <= 4'h0;
            addr_ph_q <= 1'b0;
            sda_rel_q <= 1'b1;
            int_flag_q <= 1'b1;
            if (arb_q)
            begin
              arb_q <= 1'b0;
              status_q <= SC_ARB_LOST;
            end
            else if (master_q && addr_ph_q)
            begin
              tx_q <= !shift_q[0];
              status_q <= ack_q ? SC_ADDR_NACK : SC_ADDR_ACK;
            end
            else if (master_q && tx_q)
              status_q <= ack_q ? SC_DATA_NACK : SC_DATA_ACK;
            else if (master_q)
            begin
              push_q <= 1'b1;
              status_q <= sda_rel_q ? SC_RX_NACK : SC_RX_ACK;
            end
            else if (addr_ph_q && hit && ea_q)
            begin
              addressed_q <= 1'b1;
              tx_q <= shift_q[0];
              status_q <= (shift_q[7:1] == GC_ADDR) ? SC_SLV_GC : SC_SLV_ADDR;
            end
            else if (addr_ph_q)
              int_flag_q <= 1'b0;
            else if (tx_q)
              status_q <= ack_q ? SC_SLV_TX_NACK : SC_SLV_TX_ACK;
            else
            begin
              push_q <= 1'b1;
              status_q <= SC_SLV_RX;
            end
          end
        end
        default:
        begin
          case (phase_q)
            PH_0:
            begin
              sda_rel_q <= 1'b0;
              if (half_done)
              begin
                scl_low_q <= 1'b0;
                timer_q <= 16'h0000;
                phase_q <= PH_1;
              end
            end
            PH_1:
            begin
              if (!scl_s)
                timer_q <= 16'h0000;
              else if (half_done)
              begin
                sda_rel_q <= 1'b1;
                timer_q <= 16'h0000;
                phase_q <= PH_2;
              end
            end
            default:
            begin
              if (half_done)
              begin
                state_q <= S_IDLE;
                master_q <= 1'b0;
                tx_q <= 1'b0;
                sto_q <= 1'b0;
              end
            end
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive stream; a full FIFO holds off the next receive byte
  twc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(push_q),
    .in_ready(fifo_rdy),
    .in_data(shift_q),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // Shift contents after a sleep wake-up carry no guarantee
  assign irq = int_flag_q && ie_q && global_irq_en;
  assign pin_ctrl_en = en_q;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  // Addressed slave stretches while the flag is up; master owns its own clock
  assign scl_oe_n = !(en_q && (master_q ? scl_low_q : (addressed_q && int_flag_q)));
  assign sda_oe_n = !(en_q && !sda_rel_q);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_go_sta;
    go && sta_q;
  endsequence
  sequence s_stop_end;
    (state_q == S_STOP) ##1 (state_q == S_IDLE);
  endsequence
  sequence s_start_done;
    (state_q == S_START) && (phase_q == PH_2) && half_done && en_q;
  endsequence
  a_irq_gate: assert property ($rose(int_flag_q) && ie_q && global_irq_en |-> irq)
    else $error("irq not raised with job flag");
  a_wc_set: assert property (wr_data && !int_flag_q |=> wc_q)
    else $error("collision flag not set");
  a_wc_clear: assert property (wr_data && int_flag_q |=> !wc_q)
    else $error("collision flag not cleared");
  a_data_hold: assert property (int_flag_q && !wr_data |=> $stable(shift_q))
    else $error("data changed while flag set");
  a_flag_idle: assert property (int_flag_q |-> state_q == S_IDLE)
    else $error("bus operation while flag set");
  a_go_start: assert property (s_go_sta |=> state_q inside {S_START, S_WAIT_FREE})
    else $error("start request not launched");
  a_stop_quiet: assert property (s_stop_end |-> !int_flag_q && !sto_q)
    else $error("flag set or stop bit left after stop");
  a_off_release: assert property (!en_q |=> scl_oe_n && sda_oe_n && state_q == S_IDLE)
    else $error("lines not released when disabled");
  a_stat_rsvd: assert property (reg_sel == REG_STAT |=> !reg_rdata[SB_RSVD])
    else $error("reserved status bit read as one");
  a_slv_stop: assert property (go && !sta_q && sto_q && !master_q |=> !addressed_q ##1 sda_oe_n)
    else $error("slave stop did not release");
  a_start_flag: assert property (s_start_done |=> int_flag_q && master_q)
    else $error("no job flag after start");
endmodule // twc_ctrl

// ### tb/twc_bus_slave.sv
// Purpose: Behavioural slave device on the two-wire bus
// Assumes: Both lines pulled up; master holds data stable while SCL is high
// Notes: Acks its own address and then every data byte until STOP
`timescale 1ns/1ps
module twc_bus_slave
#(
  parameter logic [6:0] ADDR = 7'h2A
)
(
  input wire logic scl, // Bus clock line
  input wire logic sda, // Bus data line
  output logic sda_pull, // Pull data low
  output logic [7:0] last_byte // Last data byte taken
);
  logic [7:0] sh;
  int cnt;
  logic adr;
  logic ack;
  logic sel;
  initial
  begin
    sda_pull = 1'b0;
    cnt = 0;
    ack = 1'b0;
    adr = 1'b0;
    sel = 1'b0;
    last_byte = 8'h00;
  end
  // START: next byte is an address
  always @(negedge sda)
    if (scl)
    begin
      cnt = 0;
      adr = 1'b1;
      ack = 1'b0;
      sda_pull = 1'b0;
    end
  always @(posedge sda)
    if (scl)
      sel = 1'b0;
  always @(posedge scl)
    if (cnt < 8)
    begin
      sh = {sh[6:0], sda};
      cnt++;
    end
  // Ack slot opens after the 8th fall, released at the 9th
  always @(negedge scl)
    if (ack)
    begin
      sda_pull = 1'b0;
      ack = 1'b0;
      cnt = 0;
      adr = 1'b0;
    end
    else if (cnt == 8)
    begin
      if (adr)
        sel = (sh[7:1] == ADDR);
      else if (sel)
        last_byte = sh;
      sda_pull = sel;
      ack = 1'b1;
    end
endmodule // twc_bus_slave

// ### tb/test_two_wire_bus_controller_regs.sv
// Purpose: Self-checking bench for the two-wire bus controller
// Assumes: One behavioural slave at address 2A on pulled-up lines
// Notes: Divider kept small under the largest prescale (64) so a byte takes a few thousand cycles
`timescale 1ns/1ps
module test_two_wire_bus_controller_regs
  import twc_pkg::*;
;
  logic clk_sys, rst, reg_wr, global_irq_en, rx_ready, irq, pin_ctrl_en;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, rx_valid, sda_pull;
  logic [2:0] reg_sel;
  logic [7:0] reg_wdata, reg_rdata, rx_data, last_byte, v, dat;
  logic [1:0] ps;
  logic [7:0] q[$];
  int num_errors, checked, cyc, i, seed;
  wire logic scl_w = scl_oe_n;
  wire logic sda_w = sda_oe_n & ~sda_pull;
  twc_ctrl i_twc_ctrl (.clk_sys(clk_sys), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en), .irq(irq),
    .pin_ctrl_en(pin_ctrl_en), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready));
  twc_bus_slave i_twc_bus_slave (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .last_byte(last_byte));
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge clk_sys);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] s);
    @(negedge clk_sys);
    reg_sel = s;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  // Polls a control bit; the cycle limit catches a hang
  task automatic wait_ctrl(input int b, input logic val);
    do rd(REG_CTRL);
    while (v[b] !== val);
  endtask
  task automatic start_addr(input logic [6:0] a);
    wr(REG_CTRL, 8'hA5);
    wait_ctrl(CB_INT, 1'b1);
    rd(REG_STAT);
    chk(v, {SC_START, 1'b0, ps});
    chk(v & 8'hF8, {SC_START, 3'b000});
    wr(REG_DATA, {a, 1'b0});
    rd(REG_CTRL);
    chk(v, 8'hA5);
    wr(REG_CTRL, 8'h85);
    wait_ctrl(CB_INT, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      results();
    end
  end
  always @(negedge clk_sys)
    rx_ready <= cyc[2];
  initial
  begin
    seed = 32'h78ace691;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_sel = REG_CTRL;
    reg_wdata = ZERO8;
    global_irq_en = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rd(REG_DATA);
    chk(v, DATA_RST);
    rd(REG_STAT);
    chk(v, {SC_NOINFO, 3'b000});
    wr(3'h5, 8'hFF);
    rd(3'h5);
    chk(v, ZERO8);
    for (i = 0; i < 4; i++)
    begin
      ps = i[1:0];
      dat = 8'($random(seed));
      wr(REG_STAT, {dat[7:2], ps});
      rd(REG_STAT);
      chk(v, {SC_NOINFO, 1'b0, ps});
    end
    wr(REG_RATE, {6'h00, dat[1:0]});
    wr(REG_ADDR, 8'h20);
    wr(REG_CTRL, 8'h04);
    chk({7'h00, pin_ctrl_en}, 8'h01);
    wr(REG_DATA, 8'h55);
    rd(REG_CTRL);
    chk(v, 8'h0C);
    rd(REG_DATA);
    chk(v, DATA_RST);
    start_addr(7'h2A);
    rd(REG_STAT);
    chk(v, {SC_ADDR_ACK, 1'b0, ps});
    chk({7'h00, irq}, 8'h01);
    global_irq_en = 1'b0;
    @(negedge clk_sys);
    chk({7'h00, irq}, 8'h00);
    global_irq_en = 1'b1;
    dat = 8'($random(seed));
    q.push_back(dat);
    wr(REG_DATA, dat);
    wr(REG_CTRL, 8'h85);
    wait_ctrl(CB_INT, 1'b1);
    rd(REG_STAT);
    chk(v, {SC_DATA_ACK, 1'b0, ps});
    chk(last_byte, q.pop_front());
    rd(REG_DATA);
    chk(v, dat);
    chk({7'h00, scl_oe_n}, 8'h00);
    wr(REG_CTRL, 8'h95);
    wait_ctrl(CB_STO, 1'b0);
    rd(REG_CTRL);
    chk(v, 8'h05);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    // Stop request while not master: no STOP, bit clears at once
    wr(REG_CTRL, 8'h95);
    wait_ctrl(CB_STO, 1'b0);
    chk(v, 8'h05);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    chk({5'h00, scl_out, sda_out, rx_valid}, 8'h00);
    start_addr(7'h11);
    rd(REG_STAT);
    chk(v, {SC_ADDR_NACK, 1'b0, ps});
    wr(REG_CTRL, 8'h00);
    rd(REG_CTRL);
    chk(v, 8'h00);
    chk({5'h00, pin_ctrl_en, scl_oe_n, sda_oe_n}, 8'h03);
    results();
  end
endmodule // test_two_wire_bus_controller_regs
